/* File: acc_pkg.sv */
`default_nettype none
package acc_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets on the AHB-Lite bus
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTL_FIRST = 8'h00;
  localparam logic [7:0] OFF_CTL_SECOND = 8'h04;
  localparam logic [7:0] OFF_PIN_ENABLE = 8'h08;
  localparam logic [7:0] OFF_PORT_DIR = 8'h0c;
  localparam logic [7:0] OFF_PULLUP = 8'h10;
  localparam logic [7:0] OFF_RES_LOW = 8'h14;
  localparam logic [7:0] OFF_RES_HIGH = 8'h18;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h1c;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h20;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CF_CH_LSB = 0;     // Channel low bits [2:0]
  localparam int CF_PWR_OFF = 5;    // Converter power off
  localparam int CF_BUSY = 6;       // Conversion busy, read only
  localparam int CF_START = 7;      // Start bit
  localparam int CS_DIV_LSB = 0;    // Clock divide code [2:0]
  localparam int CS_REF_SEL = 3;    // Reference source select
  localparam int CS_CH_HI = 4;      // Channel high bit
  localparam int IRQ_CONV = 0;      // End of conversion flag

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CTL_FIRST = 8'h20;  // Converter off
  localparam logic [7:0] RST_CTL_SECOND = 8'h00;
  localparam logic [7:0] RST_PIN = 8'h00;
  localparam logic [0:0] RST_IRQ = 1'h0;

  // ----------------------------------------------------------------
  // Conversion figures
  // ----------------------------------------------------------------
  localparam int RES_BITS = 12;                  // Result width
  localparam logic [3:0] CONV_LAST_TICK = 4'hf;  // 16 clock periods

  // Per-pin configuration carried to the pin block
  typedef struct packed {
    logic [7:0] analog_pin_enable;
    logic [7:0] port_a_direction;  // 1: pin is an output
    logic [7:0] pullup_enable;
  } acc_pin_cfg_s;

  // Control lines carried to the converter core
  typedef struct packed {
    logic converter_power_off;
    logic ref_source_select;
    logic [3:0] channel_select;
  } acc_core_cfg_s;

  // Conversion sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RESET,
    ST_CONV
  } acc_state_e;

endpackage
`default_nettype wire

/* File: acc_div.sv */
`timescale 1ns/1ps
`default_nettype none
module acc_div import acc_pkg::*; (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Control
  input wire logic restart_i,
  input wire logic [2:0] conv_clock_divide_i,
  // Conversion clock enable
  output logic tick_o
);

  // ----------------------------------------------------------------
  // Divider by two to the power of the code
  // ----------------------------------------------------------------
  logic [6:0] cnt_reg;  // Count of system clocks since the last restart
  logic [6:0] mask;     // Low bits that must all be one

  // Code 111 has no defined rate; it is taken as a divide by 128
  assign mask = 7'((8'h01 << conv_clock_divide_i) - 8'h01);
  assign tick_o = !restart_i && ((cnt_reg & mask) == mask);

  // Count restarts so the first period after a start is a full one
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_reg <= 7'h00;
    end else if (restart_i) begin
      cnt_reg <= 7'h00;
    end else begin
      cnt_reg <= cnt_reg + 7'h01;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  div_full_rate_a: assert property (
    @(posedge clock_i) disable iff (!nrst_i)
    (conv_clock_divide_i == 3'h0 && !restart_i) |-> tick_o)
    else $error("divide code zero must tick every cycle");

  div_half_rate_a: assert property (
    @(posedge clock_i) disable iff (!nrst_i)
    (tick_o && conv_clock_divide_i == 3'h1 && $stable(conv_clock_divide_i)
     ##1 (!restart_i && conv_clock_divide_i == 3'h1)) |-> !tick_o)
    else $error("divide by two ticked twice in a row");

endmodule
`default_nettype wire

/* File: acc_pins.sv */
`timescale 1ns/1ps
`default_nettype none
module acc_pins import acc_pkg::*; (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Pin configuration from the register file
  input wire acc_pin_cfg_s cfg_i,
  // Pad controls
  output logic [7:0] pin_analog_sel_o,
  output logic [7:0] pad_oe_n_o,
  output logic [7:0] pullup_en_o
);

  // ----------------------------------------------------------------
  // Pin function override
  // ----------------------------------------------------------------
  logic [7:0] oe_n_next;  // Output driver off for analog pins
  logic [7:0] pull_next;  // Pull-high only on digital pins

  assign oe_n_next = ~(cfg_i.port_a_direction & ~cfg_i.analog_pin_enable);
  assign pull_next = cfg_i.pullup_enable & ~cfg_i.analog_pin_enable;

  // Registered so pads never see a decode glitch
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_analog_sel_o <= 8'h00;
      pad_oe_n_o <= 8'hff;
      pullup_en_o <= 8'h00;
    end else begin
      pin_analog_sel_o <= cfg_i.analog_pin_enable;
      pad_oe_n_o <= oe_n_next;
      pullup_en_o <= pull_next;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  pin_route_a: assert property (
    @(posedge clock_i) disable iff (!nrst_i)
    ##1 pin_analog_sel_o == $past(cfg_i.analog_pin_enable))
    else $error("analog select does not follow enable");

  pin_pull_off_a: assert property (
    @(posedge clock_i) disable iff (!nrst_i)
    ##1 (pullup_en_o & $past(cfg_i.analog_pin_enable)) == 8'h00)
    else $error("pull-high left on an analog pin");

  pin_dir_over_a: assert property (
    @(posedge clock_i) disable iff (!nrst_i)
    ##1 (~pad_oe_n_o & $past(cfg_i.analog_pin_enable)) == 8'h00)
    else $error("analog pin still driven as output");

endmodule
`default_nettype wire

/* File: acc_top.sv */
// Added by the designer: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Analog enable routes pin, disables others
// - Analog pin drops its pull-high
// - Analog enable overrides port direction
// - Reference select bit picks pin or supply
// - Power-off bit switches converter off
// - Start high resets, falling edge converts
// - Busy high during conversion, low after
// - Result readable as low and high bytes
// - Conversion lasts sixteen conversion clocks
// - Result twelve bits, full scale all ones
// - Code step is reference over 4096
// - Conversion runs without stalling the processor
// - Divide code n gives clock over 2^n
// - End clears busy, sets interrupt flag
module acc_top import acc_pkg::*; (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Converter core
  input wire logic [11:0] adc_data_i,
  output logic conv_power_down_o,
  output logic ref_sel_o,
  output logic [3:0] chan_sel_o,
  output logic conv_reset_o,
  output logic conv_tick_o,
  // Shared pins
  output logic [7:0] pin_analog_sel_o,
  output logic [7:0] pad_oe_n_o,
  output logic [7:0] pullup_en_o,
  // Interrupt
  output logic irq_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Address match on the low byte of a word address
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic addr_ph;            // Address phase taken this cycle
  logic wr_pend_reg;        // Write data phase in progress
  logic rd_pend_reg;        // Read wait cycle in progress
  logic [7:0] addr_reg;     // Latched byte address
  logic [7:0] wdata;        // Low byte of write data
  logic [31:0] rd_mux;      // Selected read value
  logic hready_reg;         // Registered ready

  assign addr_ph = hsel_i && htrans_i[1] && hready_i;
  assign wdata = hwdata_i[7:0];
  // Only whole words are used; hsize is not decoded
  logic unused_size;
  assign unused_size = ^hsize_i;

  // Reads take one wait state so a write just ahead is always seen
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
      hready_reg <= 1'b1;
    end else begin
      wr_pend_reg <= addr_ph && hwrite_i;
      rd_pend_reg <= addr_ph && !hwrite_i;
      hready_reg <= !(addr_ph && !hwrite_i);
      if (addr_ph) begin
        addr_reg <= haddr_i[7:0];
      end
    end
  end

  // Read data is loaded in the wait cycle
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (rd_pend_reg) begin
      hrdata_o <= rd_mux;
    end
  end

  assign hreadyout_o = hready_reg;
  assign hresp_o = 1'b0;  // Always OKAY

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] ctl_first_reg;   // conv_control_first
  logic [7:0] ctl_second_reg;  // conv_control_second
  logic [7:0] pin_en_reg;      // analog_pin_enable_reg
  logic [7:0] dir_reg;         // port_a_direction
  logic [7:0] pull_reg;        // Pull-high enables
  logic [0:0] stat_reg;        // conv_irq_flag
  logic [0:0] mask_reg;        // conv_irq_enable
  logic [0:0] stat_next;
  logic [RES_BITS-1:0] result_reg;  // Last conversion result
  logic busy_reg;              // conversion_busy
  logic done;                  // Conversion end this cycle
  logic we_first, we_second, we_pin, we_dir, we_pull;
  logic we_stat, we_mask;

  assign we_first = wr_pend_reg && hit(addr_reg, OFF_CTL_FIRST);
  assign we_second = wr_pend_reg && hit(addr_reg, OFF_CTL_SECOND);
  assign we_pin = wr_pend_reg && hit(addr_reg, OFF_PIN_ENABLE);
  assign we_dir = wr_pend_reg && hit(addr_reg, OFF_PORT_DIR);
  assign we_pull = wr_pend_reg && hit(addr_reg, OFF_PULLUP);
  assign we_stat = wr_pend_reg && hit(addr_reg, OFF_IRQ_STAT);
  assign we_mask = wr_pend_reg && hit(addr_reg, OFF_IRQ_MASK);

  // Set wins over a write-one clear in the same cycle
  assign stat_next = (stat_reg & ~(we_stat ? wdata[0:0] : 1'b0))
                   | (done ? 1'b1 : 1'b0);

  // Busy bit of the first register is read-only
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctl_first_reg <= RST_CTL_FIRST;
      ctl_second_reg <= RST_CTL_SECOND;
      pin_en_reg <= RST_PIN;
      dir_reg <= RST_PIN;
      pull_reg <= RST_PIN;
      mask_reg <= RST_IRQ;
    end else begin
      if (we_first) ctl_first_reg <= wdata & ~(8'h01 << CF_BUSY);
      if (we_second) ctl_second_reg <= wdata & 8'h1f;
      if (we_pin) pin_en_reg <= wdata;
      if (we_dir) dir_reg <= wdata;
      if (we_pull) pull_reg <= wdata;
      if (we_mask) mask_reg <= wdata[0:0];
    end
  end

  // Interrupt flag and level output
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stat_reg <= RST_IRQ;
      irq_o <= 1'b0;
    end else begin
      stat_reg <= stat_next;
      irq_o <= |(stat_next & mask_reg);
    end
  end

  // Unmapped addresses read as zero
  assign rd_mux =
    hit(addr_reg, OFF_CTL_FIRST) ?
      {24'h0, ctl_first_reg | (8'(busy_reg) << CF_BUSY)} :
    hit(addr_reg, OFF_CTL_SECOND) ? {24'h0, ctl_second_reg} :
    hit(addr_reg, OFF_PIN_ENABLE) ? {24'h0, pin_en_reg} :
    hit(addr_reg, OFF_PORT_DIR) ? {24'h0, dir_reg} :
    hit(addr_reg, OFF_PULLUP) ? {24'h0, pull_reg} :
    hit(addr_reg, OFF_RES_LOW) ? {24'h0, result_reg[7:0]} :
    hit(addr_reg, OFF_RES_HIGH) ? {28'h0, result_reg[11:8]} :
    hit(addr_reg, OFF_IRQ_STAT) ? {31'h0, stat_reg} :
    hit(addr_reg, OFF_IRQ_MASK) ? {31'h0, mask_reg} :
    32'h0000_0000;

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  logic start_bit;            // Software start level
  logic pwr_off;              // converter_power_off
  logic [2:0] div_code;       // conv_clock_divide
  acc_core_cfg_s core_cfg;    // Core control lines
  acc_pin_cfg_s pin_cfg;      // Pin control lines

  assign start_bit = ctl_first_reg[CF_START];
  assign pwr_off = ctl_first_reg[CF_PWR_OFF];
  assign div_code = ctl_second_reg[CS_DIV_LSB +: 3];
  assign core_cfg.converter_power_off = pwr_off;
  assign core_cfg.ref_source_select = ctl_second_reg[CS_REF_SEL];
  assign core_cfg.channel_select = {ctl_second_reg[CS_CH_HI],
                                    ctl_first_reg[CF_CH_LSB +: 3]};
  assign pin_cfg.analog_pin_enable = pin_en_reg;
  assign pin_cfg.port_a_direction = dir_reg;
  assign pin_cfg.pullup_enable = pull_reg;

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  acc_state_e state_reg, state_next;
  logic [3:0] tick_cnt_reg;   // Conversion clocks counted
  logic tick;                 // Conversion clock enable
  logic at_last;              // Sixteenth period ends now

  assign at_last = tick && (tick_cnt_reg == CONV_LAST_TICK);
  assign done = (state_reg == ST_CONV) && !pwr_off && !start_bit
              && at_last;

  // A powered-off converter ignores start and drops any conversion
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (start_bit && !pwr_off) state_next = ST_RESET;
      end
      ST_RESET: begin
        if (pwr_off) state_next = ST_IDLE;
        else if (!start_bit) state_next = ST_CONV;
      end
      ST_CONV: begin
        if (pwr_off) state_next = ST_IDLE;
        else if (start_bit) state_next = ST_RESET;
        else if (at_last) state_next = ST_IDLE;
      end
    endcase
  end

  // The conversion never holds the processor; progress rests on the divider alone
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= ST_IDLE;
      busy_reg <= 1'b0;
      conv_reset_o <= 1'b0;
    end else begin
      state_reg <= state_next;
      busy_reg <= (state_next != ST_IDLE);
      conv_reset_o <= (state_next == ST_RESET);
    end
  end

  // Period count restarts at each falling start edge
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tick_cnt_reg <= 4'h0;
    end else if (state_reg != ST_CONV) begin
      tick_cnt_reg <= 4'h0;
    end else if (tick) begin
      tick_cnt_reg <= tick_cnt_reg + 4'h1;
    end
  end

  acc_div u_div (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .restart_i(state_reg != ST_CONV),
    .conv_clock_divide_i(div_code),
    .tick_o(tick)
  );

  // ----------------------------------------------------------------
  // Result capture
  // ----------------------------------------------------------------
  logic [RES_BITS-1:0] data_meta_reg;  // First sync stage only
  logic [RES_BITS-1:0] data_sync_reg;  // Safe to use

  // Core output is static at the end; two stages guard metastability
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      data_meta_reg <= 12'h000;
      data_sync_reg <= 12'h000;
      result_reg <= 12'h000;
    end else begin
      data_meta_reg <= adc_data_i;
      data_sync_reg <= data_meta_reg;
      if (done) result_reg <= data_sync_reg;
    end
  end

  // ----------------------------------------------------------------
  // Core and pin outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      conv_power_down_o <= 1'b1;
      ref_sel_o <= 1'b0;
      chan_sel_o <= 4'h0;
      conv_tick_o <= 1'b0;
    end else begin
      conv_power_down_o <= core_cfg.converter_power_off;
      ref_sel_o <= core_cfg.ref_source_select;
      chan_sel_o <= core_cfg.channel_select;
      conv_tick_o <= tick && (state_reg == ST_CONV);
    end
  end

  acc_pins u_pins (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .cfg_i(pin_cfg),
    .pin_analog_sel_o(pin_analog_sel_o),
    .pad_oe_n_o(pad_oe_n_o),
    .pullup_en_o(pullup_en_o)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence start_taken_s;
    state_reg == ST_IDLE && start_bit && !pwr_off;
  endsequence

  sequence conv_end_s;
    done;
  endsequence

  busy_on_start_a: assert property (
    @(posedge clock_i) disable iff (!nrst_i)
    start_taken_s |=> busy_reg && conv_reset_o)
    else $error("busy or core reset missing after start");

  end_clears_a: assert property (
    @(posedge clock_i) disable iff (!nrst_i)
    conv_end_s |=> !busy_reg && stat_reg[0])
    else $error("end of conversion did not clear busy and set flag");

  busy_held_a: assert property (
    @(posedge clock_i) disable iff (!nrst_i)
    (state_reg == ST_CONV && !done && !pwr_off) |=> busy_reg)
    else $error("busy dropped during conversion");

  conv_length_a: assert property (
    @(posedge clock_i) disable iff (!nrst_i)
    conv_end_s |-> tick_cnt_reg == 4'hf && tick)
    else $error("conversion ended before sixteen periods");

  result_load_a: assert property (
    @(posedge clock_i) disable iff (!nrst_i)
    conv_end_s |=> result_reg == $past(data_sync_reg))
    else $error("result not loaded at end of conversion");

  power_off_a: assert property (
    @(posedge clock_i) disable iff (!nrst_i)
    pwr_off |=> !busy_reg && conv_power_down_o)
    else $error("converter not held off");

  ref_select_a: assert property (
    @(posedge clock_i) disable iff (!nrst_i)
    ##1 ref_sel_o == $past(ctl_second_reg[CS_REF_SEL]))
    else $error("reference select not driven");

  irq_level_a: assert property (
    @(posedge clock_i) disable iff (!nrst_i)
    conv_end_s |=> irq_o == $past(mask_reg[0]))
    else $error("unmasked end of conversion raised no interrupt");

endmodule
`default_nettype wire

/* File: acc_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module acc_core_model import acc_pkg::*; (
  // Clock
  input wire logic clock_i,
  // Controls from the block
  input wire logic power_down_i,
  input wire logic conv_reset_i,
  input wire logic conv_tick_i,
  input wire logic [11:0] code_i,
  // Result and tick count
  output logic [11:0] adc_data_o,
  output logic [7:0] tick_cnt_o
);
  // ----------------------------------------------------------------
  // Converter core
  // ----------------------------------------------------------------
  initial begin
    adc_data_o = 12'h000;
    tick_cnt_o = 8'h00;
  end
  // Off or held in reset the output means nothing, so it toggles
  always @(posedge clock_i) begin
    if (power_down_i || conv_reset_i) begin
      adc_data_o <= ~adc_data_o;
      if (conv_reset_i) begin
        tick_cnt_o <= 8'h00;
      end
    end else if (conv_tick_i) begin
      tick_cnt_o <= tick_cnt_o + 8'h01;
      adc_data_o <= code_i;
    end
  end
endmodule
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb import acc_pkg::*;;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic hsel = 1'b0, hwrite = 1'b0, rd_ph = 1'b0, hready, hresp, irq;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [11:0] adc, code = 12'h000;
  logic pdn, rsel, crst, ctick;
  logic [3:0] chan, ch;
  logic [7:0] asel, oe_n, pull, ticks, en, dr, pu;
  logic [31:0] exq[$];
  string nmq[$];
  int miscompares = 0, check_count = 0, seed, c, n, i;
  // ----------------------------------------------------------------
  // Design and core model
  // ----------------------------------------------------------------
  acc_top uut (.clock_i(clock_i), .nrst_i(nrst_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .adc_data_i(adc), .conv_power_down_o(pdn), .ref_sel_o(rsel),
    .chan_sel_o(chan), .conv_reset_o(crst), .conv_tick_o(ctick),
    .pin_analog_sel_o(asel), .pad_oe_n_o(oe_n), .pullup_en_o(pull),
    .irq_o(irq));
  acc_core_model core (.clock_i(clock_i), .power_down_i(pdn),
    .conv_reset_i(crst), .conv_tick_i(ctick), .code_i(code),
    .adc_data_o(adc), .tick_cnt_o(ticks));
  // Clock
  initial begin
    forever #20 clock_i = ~clock_i;
  end
  // ----------------------------------------------------------------
  // Checks and bus tasks
  // ----------------------------------------------------------------
  task automatic test_done;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    check_count++;
    if (s !== e) begin
      $display("ERROR %s exp %h got %h", nm, e, s);
      miscompares++;
    end
  endtask
  // Bounded wait for hready; a hang ends the run
  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge clock_i);
      k++;
    end while (hready !== 1'b1 && k < 50);
    if (k >= 50) begin
      miscompares++;
      test_done;
    end
  endtask
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= d;
    rd_ph <= !w;
    wait_rdy;
    rd_ph <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e, string nm);
    exq.push_back(e);
    nmq.push_back(nm);
    bus(1'b0, a, 32'h0);
  endtask
  // Read data is taken at the edge that ends the data phase
  always @(posedge clock_i) begin
    if (rd_ph && hready === 1'b1 && exq.size() > 0) begin
      chk(nmq.pop_front(), exq.pop_front(), hrdata);
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 48347;
    repeat (2) @(posedge clock_i);
    nrst_i <= 1'b1;
    @(posedge clock_i);
    chk("oe_n", 32'hff, {24'h0, oe_n});
    chk("pdn", 32'h1, {31'h0, pdn});
    chk("hresp", 32'h0, {31'h0, hresp});
    rd(OFF_CTL_FIRST, {24'h0, RST_CTL_FIRST}, "first");
    bus(1'b1, 8'h24, 32'hff);
    rd(8'h24, 32'h0, "unmapped");
    // Pin sharing with random settings
    for (i = 0; i < 4; i++) begin
      en = 8'($random(seed));
      dr = 8'($random(seed));
      pu = 8'($random(seed));
      bus(1'b1, OFF_PIN_ENABLE, {24'h0, en});
      bus(1'b1, OFF_PORT_DIR, {24'h0, dr});
      bus(1'b1, OFF_PULLUP, {24'h0, pu});
      repeat (3) @(posedge clock_i);
      chk("asel", {24'h0, en}, {24'h0, asel});
      chk("pull", {24'h0, pu & ~en}, {24'h0, pull});
      chk("oe_n", {24'h0, ~(dr & ~en)}, {24'h0, oe_n});
    end
    bus(1'b1, OFF_IRQ_MASK, 32'h1);
    // Conversions at divide codes 0 to 2, full scale first
    for (n = 0; n < 3; n++) begin
      ch = 4'($random(seed));
      code <= (n == 0) ? 12'hfff : 12'($random(seed));
      bus(1'b1, OFF_CTL_SECOND, {27'h0, ch[3], n[0], n[2:0]});
      bus(1'b1, OFF_CTL_FIRST, {29'h0, ch[2:0]});
      bus(1'b1, OFF_CTL_FIRST, {24'h0, 5'h10, ch[2:0]});
      rd(OFF_CTL_FIRST, {24'h0, 5'h18, ch[2:0]}, "busy");
      chk("crst", 32'h1, {31'h0, crst});
      chk("rsel", {31'h0, n[0]}, {31'h0, rsel});
      chk("chan", {28'h0, ch}, {28'h0, chan});
      chk("pdn", 32'h0, {31'h0, pdn});
      bus(1'b1, OFF_CTL_FIRST, {29'h0, ch[2:0]});
      rd(OFF_CTL_FIRST, {24'h0, 5'h08, ch[2:0]}, "busy");
      c = 3;
      while (irq !== 1'b1 && c < 5000) begin
        @(posedge clock_i);
        c++;
      end
      chk("len", 32'h1, {31'h0, c >= (16 << n) && c <= (16 << n) + 4});
      if (c >= 5000) test_done;
      // The model counts the last tick at this edge; let it settle
      @(posedge clock_i);
      chk("ticks", 32'h10, {24'h0, ticks});
      rd(OFF_CTL_FIRST, {29'h0, ch[2:0]}, "idle");
      rd(OFF_RES_LOW, {24'h0, code[7:0]}, "res_lo");
      rd(OFF_RES_HIGH, {28'h0, code[11:8]}, "res_hi");
      rd(OFF_IRQ_STAT, 32'h1, "stat");
      bus(1'b1, OFF_IRQ_STAT, 32'h1);
      rd(OFF_IRQ_STAT, 32'h0, "stat");
      chk("irq", 32'h0, {31'h0, irq});
    end
    // Masked end of conversion keeps the line low
    bus(1'b1, OFF_IRQ_MASK, 32'h0);
    bus(1'b1, OFF_CTL_SECOND, 32'h0);
    bus(1'b1, OFF_CTL_FIRST, 32'h80);
    bus(1'b1, OFF_CTL_FIRST, 32'h00);
    repeat (40) @(posedge clock_i);
    chk("irq", 32'h0, {31'h0, irq});
    rd(OFF_IRQ_STAT, 32'h1, "stat");
    bus(1'b1, OFF_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clock_i);
    chk("irq", 32'h1, {31'h0, irq});
    bus(1'b1, OFF_IRQ_STAT, 32'h1);
    // Start while powered off is ignored
    bus(1'b1, OFF_CTL_FIRST, 32'ha0);
    bus(1'b1, OFF_CTL_FIRST, 32'h20);
    repeat (40) @(posedge clock_i);
    chk("pdn", 32'h1, {31'h0, pdn});
    rd(OFF_IRQ_STAT, 32'h0, "stat");
    test_done;
  end
endmodule
`default_nettype wire
